// file: design/pss_port.sv
// pipelined sync sram port: control sampling, burst, array and data path
// pipeline, counted in enabled edges:
//   edge 0  pins captured in the input register
//   edge 1  cycle decoded into stage 1, write data captured
//   edge 2  array written, or read into the output register
//   after 2 data_oe and data_out stand until the next enabled edge
// a held clock enable stretches every stage by the same amount, so
// the controller presents write data on the next enabled edge.
// output enable and sleep are synchronised: two edges of lag each,
// traded against a truly asynchronous output enable.
`timescale 1ns/1ps
module pss_port #(
	parameter int ADDR_W = pss_pkg::ADDR_W,
	parameter int LANES = pss_pkg::LANES,
	parameter int LANE_W = pss_pkg::LANE_W,
	parameter bit HAS_PARITY = 1'b1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] sync_address,
	input wire logic chip_select_n,
	input wire logic chip_select_second_n,
	input wire logic chip_select_high,
	input wire logic read_write_n,
	input wire logic advance_not_load,
	input wire logic clock_enable_n,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic burst_order_select,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic [LANES*LANE_W-1:0] data_in,
	output logic [LANES*LANE_W-1:0] data_out,
	output logic [LANES*LANE_W-1:0] data_oe,
	output logic asleep
);
	localparam int DATA_W = LANES * LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam int BW = pss_pkg::BURST_W;

	// --------------------------------------------------------------
	// input synchronisers for pin levels
	// --------------------------------------------------------------
	// sleep and output enable are asynchronous pins: two flops each
	logic sleep_meta_ff;
	logic sleep_ff;
	logic oe_meta_ff;
	logic oe_n_ff;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sleep_meta_ff <= 1'b0;
			sleep_ff <= 1'b0;
			oe_meta_ff <= 1'b1;
			oe_n_ff <= 1'b1;
		end else begin
			sleep_meta_ff <= sleep_request;
			sleep_ff <= sleep_meta_ff;
			oe_meta_ff <= output_enable_n;
			oe_n_ff <= oe_meta_ff;
		end
	end

	// --------------------------------------------------------------
	// input register
	// --------------------------------------------------------------
	// all synchronous pins land here on one edge; logic reads only these, except capture, which reads clock_enable_n at the pin
	logic [ADDR_W-1:0] addr_in_ff;
	logic cs_n_ff;
	logic cs2_n_ff;
	logic cs_hi_ff;
	logic rw_n_ff;
	logic adv_ff;
	logic cke_n_ff;
	logic [LANES-1:0] bw_n_ff;
	logic order_ff;
	logic [DATA_W-1:0] din_ff;
	logic sampled_ff;

	// clock enable and sleep gate stage 1, the burst state, the array and the read path
	wire run = !sleep_ff && !cke_n_ff && sampled_ff;

	// clock enable is registered on every waking edge, held or not
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cke_n_ff <= 1'b1;
			sampled_ff <= 1'b0;
		end else if (!sleep_ff) begin
			cke_n_ff <= clock_enable_n;
			sampled_ff <= 1'b1;
		end
	end

	// a suspended edge leaves the input register alone too
	wire capture = !sleep_ff && !clock_enable_n;

	// select and cycle-type pins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cs_n_ff <= 1'b1;
			cs2_n_ff <= 1'b1;
			cs_hi_ff <= 1'b0;
			rw_n_ff <= 1'b1;
			adv_ff <= 1'b0;
		end else if (capture) begin
			cs_n_ff <= chip_select_n;
			cs2_n_ff <= chip_select_second_n;
			cs_hi_ff <= chip_select_high;
			rw_n_ff <= read_write_n;
			adv_ff <= advance_not_load;
		end
	end

	// address, byte enables, burst order and write data
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr_in_ff <= '0;
			bw_n_ff <= pss_pkg::LANES_ALL_OFF[LANES-1:0];
			order_ff <= 1'b1;
			din_ff <= '0;
		end else if (capture) begin
			addr_in_ff <= sync_address;
			bw_n_ff <= byte_lane_write_n;
			order_ff <= burst_order_select;
			din_ff <= data_in;
		end
	end

	// --------------------------------------------------------------
	// cycle decode
	// --------------------------------------------------------------
	logic [ADDR_W-1:0] base_ff;
	logic [BW-1:0] count_ff;
	logic burst_write_ff;
	logic burst_live_ff;
	logic burst_ilv_ff;
	pss_pkg::pss_cycle_type stage1_ff;
	genvar g;

	wire load = !adv_ff;
	// selects matter only when an address loads
	wire selected = !cs_n_ff && !cs2_n_ff && cs_hi_ff;
	wire load_write = !rw_n_ff;
	// advance keeps burst type; rw select is not looked at here
	wire cyc_write = load ? load_write : burst_write_ff;
	wire cyc_active = load ? selected : burst_live_ff;

	// --------------------------------------------------------------
	// burst address
	// --------------------------------------------------------------
	// base_ff keeps the loaded address for the whole burst; the address
	// pins carry nothing useful on advance cycles and are not read then
	// next burst offset: linear counts, interleaved flips bits
	wire [BW-1:0] nxt_count = count_ff + pss_pkg::BURST_ONE;
	wire [BW-1:0] start_bits = base_ff[BW-1:0];
	wire [BW-1:0] lin_low = start_bits + nxt_count;
	wire [BW-1:0] ilv_low = start_bits ^ nxt_count;
	wire [BW-1:0] step_low = burst_ilv_ff ? ilv_low : lin_low;
	wire [ADDR_W-1:0] step_addr = {base_ff[ADDR_W-1:BW], step_low};
	wire [ADDR_W-1:0] cyc_addr = load ? addr_in_ff : step_addr;

	// per-lane decode: a lane writes only in a write cycle, enable low
	logic [LANES-1:0] cyc_lanes;
	generate
		for (g = 0; g < LANES; g++) begin : g_bw
			assign cyc_lanes[g] = cyc_write && !bw_n_ff[g];
		end
	endgenerate

	pss_pkg::pss_cycle_type nxt_stage1;
	assign nxt_stage1.active = cyc_active;
	assign nxt_stage1.write = cyc_write;
	assign nxt_stage1.addr = cyc_addr;
	assign nxt_stage1.lane_wr = cyc_lanes;

	// stage 1 holds the decoded cycle until the next enabled edge
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stage1_ff <= pss_pkg::CYCLE_IDLE;
		end else if (run) begin
			stage1_ff <= nxt_stage1;
		end
	end

	// burst state loads with the address and steps on advance cycles
	wire burst_load = run && load;
	wire burst_step = run && !load;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			base_ff <= '0;
			burst_write_ff <= 1'b0;
			burst_live_ff <= 1'b0;
			burst_ilv_ff <= 1'b1;
		end else if (burst_load) begin
			base_ff <= addr_in_ff;
			burst_write_ff <= load_write;
			burst_live_ff <= selected;
			burst_ilv_ff <= order_ff;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_ff <= pss_pkg::BURST_ZERO;
		end else if (burst_load) begin
			count_ff <= pss_pkg::BURST_ZERO;
		end else if (burst_step) begin
			count_ff <= nxt_count;
		end
	end

	// --------------------------------------------------------------
	// write data pipeline and array
	// --------------------------------------------------------------
	// write data follows its address by one cycle, as on the pins
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] rdata_ff;
	logic rvalid_ff;

	// lane mask: data byte plus its parity bit; no parity in x32 mode
	logic [DATA_W-1:0] lane_mask;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_mask[g*LANE_W +: LANE_W-1] =
				{(LANE_W-1){stage1_ff.lane_wr[g]}};
			assign lane_mask[g*LANE_W+LANE_W-1] =
				stage1_ff.lane_wr[g] & HAS_PARITY;
		end
	endgenerate

	wire wr_now = run && stage1_ff.active && stage1_ff.write;
	wire rd_now = run && stage1_ff.active && !stage1_ff.write;
	wire [DATA_W-1:0] old_word = mem[stage1_ff.addr];
	wire [DATA_W-1:0] new_word =
		(din_ff & lane_mask) | (old_word & ~lane_mask);

	// array has no reset: contents survive sleep and reset alike
	always_ff @(posedge mclk) begin
		if (wr_now) begin
			mem[stage1_ff.addr] <= new_word;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
		end else if (run) begin
			rvalid_ff <= rd_now;
		end
	end

	// read data is held between reads, so a frozen bus keeps its word
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else if (rd_now) begin
			rdata_ff <= old_word;
		end
	end

	// --------------------------------------------------------------
	// output drivers
	// --------------------------------------------------------------
	// x32 has no parity pins, so those bits are never driven
	logic [DATA_W-1:0] pin_mask;
	generate
		for (g = 0; g < LANES; g++) begin : g_pin
			assign pin_mask[g*LANE_W +: LANE_W-1] = '1;
			assign pin_mask[g*LANE_W+LANE_W-1] = HAS_PARITY;
		end
	endgenerate

	wire drive = rvalid_ff && !oe_n_ff && !sleep_ff;
	assign data_out = rdata_ff & pin_mask;
	assign data_oe = drive ? pin_mask : '0;

	// --------------------------------------------------------------
	// status
	// --------------------------------------------------------------
	// asleep is the synchronised request, two edges behind the pin
	assign asleep = sleep_ff;
endmodule : pss_port

// file: design/pss_pkg.sv
// package: widths, burst and pipeline constants for the sync sram port
package pss_pkg;
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int BURST_W = 2;
	localparam logic [1:0] BURST_ZERO = 2'h0;
	localparam logic [1:0] BURST_ONE = 2'h1;
	localparam logic [3:0] LANES_ALL_OFF = 4'hf;
	// the decoded cycle held in stage 1: what the cycle does and where
	typedef struct packed {
		logic active;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lane_wr;
	} pss_cycle_type;
	localparam pss_cycle_type CYCLE_IDLE = '0;
endpackage : pss_pkg

// file: sim/pss_port_asserts.sv
// checker: pin-level timing checks for the sync sram port
`timescale 1ns/1ps
module pss_port_asserts #(
	parameter int LANES = 4,
	parameter int LANE_W = 9
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic chip_select_second_n,
	input wire logic chip_select_high,
	input wire logic read_write_n,
	input wire logic advance_not_load,
	input wire logic clock_enable_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic [LANES*LANE_W-1:0] data_out,
	input wire logic [LANES*LANE_W-1:0] data_oe,
	input wire logic asleep
);
	// go: an edge that really moves the pipeline
	wire logic go = !clock_enable_n && !sleep_request && !asleep;
	wire logic load = go && !advance_not_load;
	wire logic off = chip_select_n | chip_select_second_n | !chip_select_high;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	chk_freeze_out: assert property (clock_enable_n && !sleep_request
		&& !asleep |=> ##1 $stable(data_out)) else $error("moved while held");
	chk_desel_quiet: assert property (load && off ##1 go
		|=> ##1 data_oe == '0) else $error("deselect drove bus");
	chk_write_quiet: assert property (load && !read_write_n ##1 go
		|=> ##1 data_oe == '0) else $error("write drove bus");
	chk_read_drive: assert property (load && read_write_n && !off
		##1 (go && !output_enable_n) |=> ##1 data_oe == '1)
		else $error("read not driven");
	chk_sleep_quiet: assert property (asleep |-> data_oe == '0)
		else $error("driven while asleep");
	chk_sleep_enter: assert property (sleep_request [*4] |=> asleep)
		else $error("no standby");
	chk_sleep_leave: assert property (!sleep_request [*4] |=> !asleep)
		else $error("stuck in standby");
	chk_oe_off: assert property (output_enable_n [*3] |=> data_oe == '0)
		else $error("driven with enable off");
	cover property (load && read_write_n && !off);
	cover property (clock_enable_n [*2]);
	cover property ($rose(asleep));
endmodule : pss_port_asserts

// file: sim/pss_ctrl.sv
// controller model: one bus cycle per call, write data one edge late
`timescale 1ns/1ps
module pss_ctrl (
	input wire logic mclk,
	output logic [17:0] sync_address,
	output logic chip_select_n,
	output logic chip_select_second_n,
	output logic chip_select_high,
	output logic read_write_n,
	output logic advance_not_load,
	output logic clock_enable_n,
	output logic [3:0] byte_lane_write_n,
	output logic [35:0] data_in
);
	logic [35:0] pend = '0;
	initial begin
		{sync_address, chip_select_high, read_write_n, advance_not_load} = '0;
		{chip_select_n, chip_select_second_n, clock_enable_n} = '1;
		{byte_lane_write_n, data_in} = '1;
	end
	task op(input logic ce, adv, rw, input logic [2:0] sel,
		input logic [17:0] a, input logic [3:0] bw, input logic [35:0] d);
		@(posedge mclk);
		clock_enable_n <= ce;
		advance_not_load <= adv;
		read_write_n <= rw;
		{chip_select_n, chip_select_second_n, chip_select_high} <= sel;
		sync_address <= a;
		byte_lane_write_n <= (rw && !adv) ? 4'hf : bw;
		// a held edge keeps the data: the pending write still needs it
		if (!ce) begin
			data_in <= pend;
			pend = d;
		end
	endtask : op
endmodule : pss_ctrl

// file: sim/pss_port_bench.sv
// bench: controller model, read scoreboard, watchdog
`timescale 1ns/1ps
module pss_port_bench;
	logic mclk = 0, rst_n = 0, output_enable_n = 1, sleep_request = 0;
	logic burst_order_select = 0;
	logic chip_select_n, chip_select_second_n, chip_select_high, moved;
	logic read_write_n, advance_not_load, clock_enable_n, asleep;
	logic [17:0] sync_address;
	logic [3:0] byte_lane_write_n;
	logic [35:0] data_in, data_out, data_oe, d, want, mem[8], q[$];
	logic [31:0] r;
	int error_cnt = 0, n_compared = 0, seed = 32'h370451cd, i;
	pss_ctrl ctl (.*);
	pss_port uut (.*);
	initial forever #10 mclk = ~mclk;
	task final_report;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	task cmp(input logic [35:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task wr(input logic [2:0] a, input logic [3:0] bw, input logic adv);
		r = $random(seed);
		d = {r[3:0], 32'($random(seed))};
		for (int g = 0; g < 4; g++)
			if (!bw[g]) mem[a][9*g +: 9] = d[9*g +: 9];
		ctl.op(0, adv, adv & r[4], adv ? r[7:5] : 3'h1,
			adv ? r[25:8] : 18'(a), bw, d);
	endtask : wr
	// advance cycles carry stray write enables: a burst must stay a read
	task rd(input logic [2:0] a, input logic adv);
		r = $random(seed);
		q.push_back(mem[a]);
		ctl.op(0, adv, !adv | r[4], adv ? r[7:5] : 3'h1,
			adv ? r[25:8] : 18'(a), r[11:8], '0);
	endtask : rd
	task hold;
		r = $random(seed);
		ctl.op(1, r[0], r[1], r[4:2], r[22:5], r[26:23], '0);
	endtask : hold
	task idle(input int n);
		repeat (n) ctl.op(0, 0, 1, 3'h4, '0, 4'hf, '0);
	endtask : idle
	always @(posedge mclk) moved <= !clock_enable_n;
	always @(negedge mclk) begin
		if (moved && data_oe !== '0) begin
			want = q.size() ? q.pop_front() : 'x;
			cmp(data_out, want);
			cmp(data_oe, '1);
		end
	end
	initial begin
		#20us;
		error_cnt++;
		final_report;
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		output_enable_n <= 0;
		for (i = 0; i < 8; i++) wr(i[2:0], 4'h0, 0);
		for (i = 0; i < 8; i++) rd(i[2:0], 0);
		for (i = 0; i < 4; i++) wr({1'b1, 2'(i + 2)}, 4'h0, i != 0);
		for (i = 0; i < 4; i++) rd({1'b1, 2'(i + 1)}, i != 0);
		repeat (40) begin
			r = $random(seed);
			if (r[0]) wr(r[3:1], r[7:4], 0);
			else rd(r[3:1], 0);
		end
		rd(1, 0);
		hold;
		hold;
		wr(2, 4'h5, 0);
		hold;
		rd(2, 0);
		for (i = 0; i < 3; i++) begin
			ctl.op(0, 0, 0, 3'h1 ^ (3'h1 << i), '0, 4'h0, '1);
			ctl.op(0, 1, 0, 3'h1, '0, 4'h0, '0);
		end
		rd(0, 0);
		rd(1, 0);
		idle(4);
		output_enable_n <= 1;
		ctl.op(0, 0, 1, 3'h1, '0, 4'hf, '0);
		idle(4);
		output_enable_n <= 0;
		sleep_request <= 1;
		idle(4);
		cmp(36'(asleep), 36'h1);
		ctl.op(0, 0, 0, 3'h1, '0, 4'h0, '0);
		idle(2);
		sleep_request <= 0;
		idle(6);
		rd(0, 0);
		idle(6);
		cmp(36'(q.size()), '0);
		final_report;
	end
endmodule : pss_port_bench
bind pss_port pss_port_asserts #(.LANES(LANES), .LANE_W(LANE_W)) chk (.*);
